// *** src/isp_dev.sv ***
// Functional notes
// - memory writes only after enable, reset low
// - chip erase sets flash and eeprom FF
// - programmer keeps each clock phase long enough
// - capture on rising, shift out on falling
// - programmer holds reset and clock low first
// - programmer waits before enable instruction
// - echo second enable byte during third
// - programmer sends all four bytes, resyncs (the host never checks the echo and only resyncs when session_i drops)
// - flash loaded by word, committed per page
// - programmer loads low byte before high
// - eeprom byte write overwrites the location
// - eeprom page commit alters only loaded bytes
// - reads return stored content at address
// - reset high ends programming mode
// - programmer waits write times without polling
// - poll status bit zero shows idle
// - flash addresses are word addresses
// - zero means programmed, one unprogrammed
// - four-byte frames, enable erase poll codes
// - page load opcodes and fields
// - read opcodes and fields
// - write opcodes and fields
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_dev #(
    parameter int FLASH_WAIT_CYC = `ISP_FLASH_WAIT_CYC,
    parameter int EE_WAIT_CYC = `ISP_EE_WAIT_CYC,
    parameter int ERASE_WAIT_CYC = `ISP_ERASE_WAIT_CYC,
    // arbitrary identification value
    parameter logic [31:0] SIG_BYTES = 32'h0012_3456,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // programming link
    isp_if.dev link,
    // application side
    input wire logic [7:0] flash_addr_i,
    output logic [15:0] flash_data_o,
    output logic prog_mode_o,
    output logic write_pending_flag_o,
    output logic [7:0] lock_o,
    output logic [7:0] fuse_lo_o,
    output logic [7:0] fuse_hi_o,
    output logic [7:0] fuse_ext_o
);
    isp_pkg::isp_dev_t q, n;
    logic rise, fall, sess;
    logic [7:0] shn, rdv;

    assign link.miso = q.miso;
    assign flash_data_o = q.rd;
    assign prog_mode_o = q.enabled;
    assign write_pending_flag_o = (q.busy != 17'd0);
    assign lock_o = q.lock;
    assign fuse_lo_o = q.fuse_lo;
    assign fuse_hi_o = q.fuse_hi;
    assign fuse_ext_o = q.fuse_ext;

    always_comb begin
        n = q;
        // pin synchronisers
        n.rst_s = {q.rst_s[0], link.rst_n};
        n.sck_s = {q.sck_s[1:0], link.sck};
        n.mosi_s = {q.mosi_s[0], link.mosi};
        sess = ~q.rst_s[1];
        rise = q.sck_s[1] & ~q.sck_s[2];
        fall = ~q.sck_s[1] & q.sck_s[2];
        shn = {q.sh[6:0], q.mosi_s[1]};
        n.rd = q.flash[flash_addr_i];
        if (q.busy != 17'd0) begin
            n.busy = q.busy - 17'd1;
        end
        // answer byte for the fourth slot
        rdv = shn;
        if (q.enabled) begin
            case (q.b1)
                `ISP_OP_POLL: rdv = {7'h00, (q.busy != 17'd0)};
                `ISP_OP_RD_HI: rdv = q.flash[shn][15:8];
                `ISP_OP_RD_LO: rdv = q.flash[shn][7:0];
                `ISP_OP_RD_EE: rdv = q.ee[shn[5:0]];
                `ISP_OP_RD_LOCK: begin
                    rdv = (q.b2 == `ISP_B2_SEL_HI) ? q.fuse_hi : q.lock;
                end
                `ISP_OP_RD_FUSE: begin
                    rdv = (q.b2 == `ISP_B2_SEL_HI) ? q.fuse_ext : q.fuse_lo;
                end
                `ISP_OP_RD_SIG: rdv = SIG_BYTES[{shn[1:0], 3'b000} +: 8];
                `ISP_OP_RD_CAL: rdv = CAL_BYTE;
                default: rdv = shn;
            endcase
        end
        if (!sess) begin
            // session over: realign framing and lock again
            n.bitcnt = 3'd0;
            n.bytecnt = 2'd0;
            n.enabled = 1'b0;
            n.tx = 8'h00;
            n.miso = 1'b0;
        end else if (rise) begin
            n.sh = shn;
            n.bitcnt = q.bitcnt + 3'd1;
            if (q.bitcnt == 3'd7) begin
                n.bytecnt = q.bytecnt + 2'd1;
                case (q.bytecnt)
                    2'd0: begin
                        n.b1 = shn;
                        n.tx = shn;
                    end
                    2'd1: begin
                        n.b2 = shn;
                        n.tx = shn;
                    end
                    2'd2: begin
                        n.b3 = shn;
                        n.tx = rdv;
                    end
                    default: begin
                        n.tx = 8'h00;
                        if (q.b1 == `ISP_OP_PROG && q.b2 == `ISP_B2_ENABLE) begin
                            n.enabled = 1'b1;
                        end else if (q.enabled && q.busy == 17'd0) begin
                            case (q.b1)
                                `ISP_OP_PROG: begin
                                    case (q.b2)
                                        `ISP_B2_ERASE: begin
                                            n.flash = '1;
                                            n.ee = '1;
                                            n.pbuf = '1;
                                            n.lock = `ISP_LOCK_RST;
                                            n.busy = 17'(ERASE_WAIT_CYC);
                                        end
                                        `ISP_B2_WR_LOCK: n.lock = shn;
                                        `ISP_B2_WR_FUSE: n.fuse_lo = shn;
                                        `ISP_B2_WR_FHI: n.fuse_hi = shn;
                                        `ISP_B2_WR_FEXT: n.fuse_ext = shn;
                                        default: n.tx = 8'h00;
                                    endcase
                                end
                                `ISP_OP_LD_HI: n.pbuf[q.b3[5:0]][15:8] = shn;
                                `ISP_OP_LD_LO: n.pbuf[q.b3[5:0]][7:0] = shn;
                                `ISP_OP_LD_EE: begin
                                    n.epbuf[q.b3[1:0]] = shn;
                                    n.eld[q.b3[1:0]] = 1'b1;
                                end
                                `ISP_OP_WR_FL: begin
                                    for (int i = 0; i < 64; i++) begin
                                        n.flash[{q.b3[7:6], 6'(i)}] = q.pbuf[i];
                                    end
                                    n.pbuf = '1;
                                    n.busy = 17'(FLASH_WAIT_CYC);
                                end
                                `ISP_OP_WR_EE: begin
                                    n.ee[q.b3[5:0]] = shn;
                                    n.busy = 17'(EE_WAIT_CYC);
                                end
                                `ISP_OP_WR_EEP: begin
                                    for (int i = 0; i < 4; i++) begin
                                        if (q.eld[i]) begin
                                            n.ee[{q.b3[5:2], 2'(i)}] = q.epbuf[i];
                                        end
                                    end
                                    n.eld = 4'h0;
                                    n.busy = 17'(EE_WAIT_CYC);
                                end
                                default: n.tx = 8'h00;
                            endcase
                        end
                    end
                endcase
            end
        end else if (fall) begin
            n.miso = q.tx[3'd7 - q.bitcnt];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q <= '1;
            q.sck_s <= 3'b000;
            q.mosi_s <= 2'b00;
            q.bitcnt <= 3'd0;
            q.bytecnt <= 2'd0;
            q.sh <= 8'h00;
            q.b1 <= 8'h00;
            q.b2 <= 8'h00;
            q.b3 <= 8'h00;
            q.tx <= 8'h00;
            q.miso <= 1'b0;
            q.enabled <= 1'b0;
            q.busy <= 17'd0;
            q.lock <= `ISP_LOCK_RST;
            q.fuse_lo <= `ISP_FUSE_RST;
            q.fuse_hi <= `ISP_FUSE_RST;
            q.fuse_ext <= `ISP_FUSE_RST;
            q.eld <= 4'h0;
        end else begin
            q <= n;
        end
    end
endmodule : isp_dev

// *** src/isp_defs.svh ***
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// clock rate
`define ISP_CLK_MHZ 10

// link timing
`define ISP_SCK_MIN_PHASE_CYC 2
`define ISP_SCK_HALF_CYC 8
`define ISP_RST_PULSE_CYC 2
`define ISP_PE_WAIT_US 20000
`define ISP_PE_WAIT_CYC (`ISP_PE_WAIT_US * `ISP_CLK_MHZ)

// self-timed write durations
`define ISP_FLASH_WAIT_US 4500
`define ISP_EE_WAIT_US 3600
`define ISP_ERASE_WAIT_US 9000
`define ISP_FLASH_WAIT_CYC (`ISP_FLASH_WAIT_US * `ISP_CLK_MHZ)
`define ISP_EE_WAIT_CYC (`ISP_EE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_ERASE_WAIT_CYC (`ISP_ERASE_WAIT_US * `ISP_CLK_MHZ)

// instruction bytes
`define ISP_OP_PROG 8'hAC
`define ISP_B2_ENABLE 8'h53
`define ISP_B2_ERASE 8'h80
`define ISP_B2_WR_LOCK 8'hE0
`define ISP_B2_WR_FUSE 8'hA0
`define ISP_B2_WR_FHI 8'hA8
`define ISP_B2_WR_FEXT 8'hA4
`define ISP_B2_SEL_HI 8'h08
`define ISP_OP_POLL 8'hF0
`define ISP_OP_LD_EXT 8'h4D
`define ISP_OP_LD_HI 8'h48
`define ISP_OP_LD_LO 8'h40
`define ISP_OP_LD_EE 8'hC1
`define ISP_OP_RD_HI 8'h28
`define ISP_OP_RD_LO 8'h20
`define ISP_OP_RD_EE 8'hA0
`define ISP_OP_RD_LOCK 8'h58
`define ISP_OP_RD_FUSE 8'h50
`define ISP_OP_RD_SIG 8'h30
`define ISP_OP_RD_CAL 8'h38
`define ISP_OP_WR_FL 8'h4C
`define ISP_OP_WR_EE 8'hC0
`define ISP_OP_WR_EEP 8'hC2

// reset and erased values
`define ISP_ERASED 8'hFF
`define ISP_FUSE_RST 8'hFF
`define ISP_LOCK_RST 8'hFF

`endif

// *** src/isp_pkg.sv ***
package isp_pkg;

    typedef struct packed {
        logic [1:0] rst_s;
        logic [2:0] sck_s;
        logic [1:0] mosi_s;
        logic [2:0] bitcnt;
        logic [1:0] bytecnt;
        logic [7:0] sh;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] tx;
        logic miso;
        logic enabled;
        logic [16:0] busy;
        logic [7:0] lock;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] fuse_ext;
        logic [15:0] rd;
        logic [3:0] eld;
        logic [3:0][7:0] epbuf;
        logic [63:0][15:0] pbuf;
        logic [63:0][7:0] ee;
        logic [255:0][15:0] flash;
    } isp_dev_t;

    typedef enum logic [4:0] {
        H_OFF = 5'b00001,
        H_WAIT = 5'b00010,
        H_IDLE = 5'b00100,
        H_SHIFT = 5'b01000,
        H_PUSH = 5'b10000
    } isp_hstate_t;

    typedef struct packed {
        isp_hstate_t state;
        logic rst_n;
        logic sck;
        logic mosi;
        logic [17:0] wcnt;
        logic [3:0] hcnt;
        logic [4:0] bitn;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [1:0] miso_s;
    } isp_host_t;

endpackage : isp_pkg

// *** src/isp_if.sv ***
`timescale 1ns/1ps
interface isp_if;
    logic rst_n;
    logic sck;
    logic mosi;
    logic miso;
    modport dev (input rst_n, input sck, input mosi, output miso);
    modport prog (output rst_n, output sck, output mosi, input miso);
endinterface : isp_if

// *** src/isp_buf.sv ***
`timescale 1ns/1ps
module isp_buf #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } isp_buf_t;

    isp_buf_t q, n;
    logic push, pop;

    assign in_ready_o = (q.cnt != 2'd2);
    assign out_valid_o = (q.cnt != 2'd0);
    assign out_data_o = q.mem[q.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data_i;
            n.wp = ~q.wp;
        end
        if (pop) begin
            n.rp = ~q.rp;
        end
        n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule : isp_buf

// *** src/isp_host.sv ***
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_host #(
    parameter int PE_WAIT_CYC = `ISP_PE_WAIT_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // programming link
    isp_if.prog link,
    // session control
    input wire logic session_i,
    // instructions in
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [31:0] cmd_data_i,
    // answers out
    output logic resp_valid_o,
    input wire logic resp_ready_i,
    output logic [31:0] resp_data_o
);
    isp_pkg::isp_host_t q, n;
    logic push_ready;

    assign link.rst_n = q.rst_n;
    assign link.sck = q.sck;
    assign link.mosi = q.mosi;
    assign cmd_ready_o = (q.state == isp_pkg::H_IDLE);

    isp_buf #(
        .W(32)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(q.state == isp_pkg::H_PUSH),
        .in_ready_o(push_ready),
        .in_data_i(q.rx),
        .out_valid_o(resp_valid_o),
        .out_ready_i(resp_ready_i),
        .out_data_o(resp_data_o)
    );

    always_comb begin
        n = q;
        n.miso_s = {q.miso_s[0], link.miso};
        case (q.state)
            isp_pkg::H_OFF: begin
                n.rst_n = 1'b1;
                n.sck = 1'b0;
                n.mosi = 1'b0;
                if (q.wcnt < 18'(`ISP_RST_PULSE_CYC)) begin
                    n.wcnt = q.wcnt + 18'd1;
                end else if (session_i) begin
                    n.state = isp_pkg::H_WAIT;
                    n.rst_n = 1'b0;
                    n.wcnt = 18'd0;
                end
            end
            isp_pkg::H_WAIT: begin
                if (q.wcnt >= 18'(PE_WAIT_CYC - 1)) begin
                    n.state = isp_pkg::H_IDLE;
                end else begin
                    n.wcnt = q.wcnt + 18'd1;
                end
            end
            isp_pkg::H_IDLE: begin
                if (cmd_valid_i) begin
                    n.state = isp_pkg::H_SHIFT;
                    n.tx = cmd_data_i;
                    n.mosi = cmd_data_i[31];
                    n.bitn = 5'd0;
                    n.hcnt = 4'd0;
                end
            end
            isp_pkg::H_SHIFT: begin
                if (q.hcnt == 4'(`ISP_SCK_HALF_CYC - 1)) begin
                    n.hcnt = 4'd0;
                    if (!q.sck) begin
                        n.sck = 1'b1;
                        n.rx = {q.rx[30:0], q.miso_s[1]};
                    end else begin
                        n.sck = 1'b0;
                        n.tx = {q.tx[30:0], 1'b0};
                        n.mosi = q.tx[30];
                        n.bitn = q.bitn + 5'd1;
                        if (q.bitn == 5'd31) begin
                            n.state = isp_pkg::H_PUSH;
                        end
                    end
                end else begin
                    n.hcnt = q.hcnt + 4'd1;
                end
            end
            isp_pkg::H_PUSH: begin
                if (push_ready) begin
                    n.state = isp_pkg::H_IDLE;
                end
            end
            default: n.state = isp_pkg::H_OFF;
        endcase
        if (!session_i && q.state != isp_pkg::H_OFF) begin
            n.state = isp_pkg::H_OFF;
            n.rst_n = 1'b1;
            n.sck = 1'b0;
            n.mosi = 1'b0;
            n.wcnt = 18'd0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.state <= isp_pkg::H_OFF;
            q.rst_n <= 1'b1;
        end else begin
            q <= n;
        end
    end
endmodule : isp_host

// *** verification/isp_checker.sv ***
`timescale 1ns/1ps
module isp_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // programming link
    input wire logic rst_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso
);
    logic sck_q;
    logic done_q;
    logic [4:0] bit_q;
    logic [31:0] mo_q;
    logic [31:0] mi_q;
    wire rise = sck && !sck_q;

    // frame tracker, bits counted from reset low
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || rst_n) begin
            sck_q <= 1'b0;
            done_q <= 1'b0;
            bit_q <= 5'h00;
        end else begin
            sck_q <= sck;
            done_q <= rise && bit_q == 5'h1f;
            if (rise) begin
                bit_q <= bit_q + 5'h01;
            end
        end
        if (rise) begin
            mo_q <= {mo_q[30:0], mosi};
            mi_q <= {mi_q[30:0], miso};
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence hi_phase;
        (sck || rst_n) [*3];
    endsequence

    sequence lo_phase;
        !sck [*3];
    endsequence

    sequence poll_done;
        done_q && mo_q[31:24] == 8'hF0;
    endsequence

    sck_high_a: assert property ($rose(sck) |-> hi_phase)
        else $error("serial clock high phase too short");
    sck_low_a: assert property ($fell(sck) && !rst_n |-> lo_phase)
        else $error("serial clock low phase too short");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data in changed while clock high");
    miso_edge_a: assert property ($changed(miso) && !rst_n |-> !sck && !$past(sck, 2))
        else $error("data out changed away from falling edge");
    idle_clock_a: assert property (rst_n |-> !sck)
        else $error("serial clock active outside session");
    reset_pulse_a: assert property ($rose(rst_n) |=> rst_n)
        else $error("reset pulse shorter than two cycles");
    echo_bytes_a: assert property (done_q |-> mi_q[23:8] == mo_q[31:16])
        else $error("echo bytes wrong");
    lead_zero_a: assert property (done_q |-> mi_q[31:24] == 8'h00)
        else $error("first answer byte not zero");
    poll_status_a: assert property (poll_done |-> mi_q[7:1] == 7'h00)
        else $error("poll status upper bits not zero");
endmodule : isp_checker

// *** verification/serial_isp_command_engine_bench.sv ***
`timescale 1ns/1ps
module serial_isp_command_engine_bench;
    localparam logic [31:0] SIG = 32'h0012_3456; // arbitrary value
    localparam logic [7:0] CAL = 8'h80; // arbitrary value
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic session = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [31:0] cmd_data = 32'h0000_0000;
    logic resp_valid;
    logic resp_ready = 1'b1;
    logic [31:0] resp_data;
    logic [7:0] flash_addr = 8'h00;
    logic [15:0] flash_data;
    logic prog_mode;
    logic pending;
    logic [7:0] lock, fuse_lo, fuse_hi, fuse_ext;
    logic [31:0] rsp;
    logic [31:0] wr_t [4] = '{32'hACE0_00FC, 32'hACA0_00E2, 32'hACA8_00D9, 32'hACA4_00FD};
    logic [31:0] rd_t [4] = '{32'h5800_0000, 32'h5000_0000, 32'h5808_0000, 32'h5008_0000};
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    isp_if lnk ();

    isp_host #(.PE_WAIT_CYC(20)) i_isp_host (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .link(lnk.prog), .session_i(session),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_data_i(cmd_data),
        .resp_valid_o(resp_valid), .resp_ready_i(resp_ready), .resp_data_o(resp_data));

    isp_dev #(.FLASH_WAIT_CYC(40), .EE_WAIT_CYC(30), .ERASE_WAIT_CYC(600),
        .SIG_BYTES(SIG), .CAL_BYTE(CAL)) i_isp_dev (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .link(lnk.dev),
        .flash_addr_i(flash_addr), .flash_data_o(flash_data), .prog_mode_o(prog_mode),
        .write_pending_flag_o(pending), .lock_o(lock), .fuse_lo_o(fuse_lo),
        .fuse_hi_o(fuse_hi), .fuse_ext_o(fuse_ext));

    isp_checker i_isp_checker (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .rst_n(lnk.rst_n),
        .sck(lnk.sck), .mosi(lnk.mosi), .miso(lnk.miso));

    always #50 sys_clk = ~sys_clk;

    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            report_and_stop();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task send(input logic [31:0] c);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_data <= c;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 4000);
        cmd_valid <= 1'b0;
        if (n >= 4000) err_count++;
    endtask : send

    task recv(output logic [31:0] r);
        int n;
        n = 0;
        resp_ready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 4000);
        r = resp_data;
        if (n >= 4000) err_count++;
    endtask : recv

    task op(input logic [31:0] c);
        send(c);
        recv(rsp);
    endtask : op

    task rd(input logic [31:0] c, input logic [7:0] e);
        op(c);
        chk(rsp[7:0], e);
    endtask : rd

    // write pending rises after a write and falls by itself
    task pend();
        int n;
        n = 0;
        while (pending !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk(pending, 1'b1);
        while (pending !== 1'b0 && n < 700) begin
            @(posedge sys_clk);
            n++;
        end
        chk(pending, 1'b0);
    endtask : pend

    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({prog_mode, pending, flash_data}, 18'h0_FFFF);
        chk({lock, fuse_lo, fuse_hi, fuse_ext}, 32'hFFFF_FFFF);
        session <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk(cmd_ready, 1'b0);
        op(32'hACA0_0000);
        op(32'hC000_0700);
        chk(fuse_lo, 8'hFF);
        op(32'hAC53_0000);
        chk(rsp[15:8], 8'h53);
        chk(prog_mode, 1'b1);
        $display("test enable done");
        op(32'h4000_0534);
        op(32'h4800_0512);
        op(32'h4000_3F78);
        op(32'h4800_3F56);
        op(32'h4C00_0000);
        pend();
        op(32'h4000_C59A);
        op(32'h4800_C5BC);
        op(32'h4C00_4000);
        pend();
        rd(32'h2000_0500, 8'h34);
        rd(32'h2800_0500, 8'h12);
        rd(32'h2000_3F00, 8'h78);
        rd(32'h2800_3F00, 8'h56);
        rd(32'h2000_4500, 8'h9A);
        rd(32'h2800_4500, 8'hBC);
        rd(32'h2000_0600, 8'hFF);
        flash_addr <= 8'h45;
        repeat (2) @(posedge sys_clk);
        chk(flash_data, 16'hBC9A);
        $display("test flash done");
        rd(32'hA000_0700, 8'hFF);
        op(32'hC000_03AA);
        pend();
        op(32'hC000_0355);
        pend();
        rd(32'hA000_0300, 8'h55);
        op(32'hC000_0499);
        pend();
        op(32'hC100_0111);
        op(32'hC100_0222);
        op(32'hC200_0400);
        pend();
        rd(32'hA000_0400, 8'h99);
        rd(32'hA000_0500, 8'h11);
        rd(32'hA000_0600, 8'h22);
        rd(32'hA000_0700, 8'hFF);
        $display("test eeprom done");
        for (int i = 0; i < 4; i++) begin
            op(wr_t[i]);
            rd(rd_t[i], wr_t[i][7:0]);
        end
        chk({lock, fuse_lo, fuse_hi, fuse_ext}, 32'hFCE2_D9FD);
        for (int i = 0; i < 3; i++) begin
            rd({16'h3000, 8'(i), 8'h00}, SIG[8*i +: 8]);
        end
        rd(32'h3800_0000, CAL);
        $display("test fuse done");
        op(32'hAC80_0000);
        rd(32'hF000_0000, 8'h01);
        rd(32'hF000_0000, 8'h00);
        rd(32'h2800_4500, 8'hFF);
        rd(32'h2000_0500, 8'hFF);
        rd(32'hA000_0300, 8'hFF);
        chk({lock, fuse_lo}, 16'hFFE2);
        $display("test erase done");
        resp_ready <= 1'b0;
        repeat (3) send(32'hF000_0000);
        repeat (600) @(posedge sys_clk);
        chk({resp_valid, cmd_ready}, 2'b10);
        repeat (3) begin
            recv(rsp);
            chk(rsp, 32'h00F0_0000);
        end
        @(posedge sys_clk);
        chk(resp_valid, 1'b0);
        $display("test buffer done");
        session <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(prog_mode, 1'b0);
        session <= 1'b1;
        send(32'hAC53_0000);
        repeat (150) @(posedge sys_clk);
        session <= 1'b0;
        repeat (20) @(posedge sys_clk);
        session <= 1'b1;
        op(32'hACA0_0011);
        chk(fuse_lo, 8'hE2);
        op(32'hAC53_0000);
        chk(rsp[15:8], 8'h53);
        chk(prog_mode, 1'b1);
        $display("test session done");
        report_and_stop();
    end
endmodule : serial_isp_command_engine_bench
